// file: verilog/cg_defs.svh
// offsets, field positions, reset values and timing counts of the clock generator controls
`ifndef CG_DEFS_SVH
`define CG_DEFS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define CG_OFS_SPREAD 7'h00
`define CG_OFS_UNUSED1 7'h01
`define CG_OFS_UNUSED2 7'h02
`define CG_OFS_DIFF 7'h03
`define CG_OFS_UNUSED4 7'h04
`define CG_OFS_IDENT 7'h05
`define CG_OFS_UNUSED6 7'h06

// ***************************************************************
// field positions
// ***************************************************************
`define CG_B0_SPREAD 7
`define CG_B0_GLOBAL_OE 5
`define CG_B0_REF_OE 0
`define CG_B3_EN0 1
`define CG_B3_EN1 2
`define CG_B3_EN2 4
`define CG_B3_EN3 5

// ***************************************************************
// reset values
// ***************************************************************
`define CG_RST_SPREAD 1'h1
`define CG_RST_GLOBAL_OE 1'h1
`define CG_RST_REF_OE 1'h1
`define CG_RST_DIFF_EN 4'hf

// ***************************************************************
// identity and serial constants (identity values arbitrary)
// ***************************************************************
`define CG_REV_CODE 4'h3
`define CG_MAKER_CODE 4'h5
`define CG_SLAVE_ADDR 7'h69
`define CG_BLOCK_CMD 8'h00
`define CG_BLOCK_COUNT 8'h07

// ***************************************************************
// timing
// ***************************************************************
`define CG_CLK_NS 10
`define CG_PD_MIN_NS 100
`define CG_PD_MIN_CYC ((`CG_PD_MIN_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)

`endif

// file: verilog/cg_pkg.sv
// types shared by the clock generator control logic
package cg_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_CNT,
    ST_WR,
    ST_RD
  } cg_state_t;

  // register access carried from the link domain to the system domain
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } cg_req_t;

endpackage

// file: verilog/cg_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module cg_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // level in, level out
  input wire logic d,
  output logic q
);

  logic meta_r;
  logic q_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule // cg_sync

// file: verilog/cg_ctrl_regs.sv
// control register bank of the clock generator with its serial slave and output gating
`timescale 1ns/100ps
`include "cg_defs.svh"
module cg_ctrl_regs (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial link oversampling clock
  input wire logic smb_clk,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // hardware power-down pin
  input wire logic hw_powerdown_n,
  // clock output controls
  output logic spread_on,
  output logic [3:0] diff_drive,
  output logic ref_oe,
  output logic ref_run,
  output logic ref_weak_pd
);

  // ***************************************************************
  // link domain: reset and pin synchronisers
  // ***************************************************************
  logic rst_link;
  logic scl_s;
  logic sda_s;
  logic ack_s;

  cg_sync #(.RST_VAL(1'b1)) u_rst_sync (
    .clk(smb_clk), .rst(1'b0), .d(rst), .q(rst_link)
  );
  cg_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clk(smb_clk), .rst(rst_link), .d(scl_i), .q(scl_s)
  );
  cg_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clk(smb_clk), .rst(rst_link), .d(sda_i), .q(sda_s)
  );

  // ***************************************************************
  // link domain: bus events
  // ***************************************************************
  cg_pkg::cg_state_t st_r;
  cg_pkg::cg_state_t nxt_st_r;
  cg_pkg::cg_state_t dec_st;
  cg_pkg::cg_req_t req_pl_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [3:0] bits_r;
  logic [7:0] shift_r;
  logic in_ack_r;
  logic mack_r;
  logic blk_r;
  logic cnt_pend_r;
  logic [7:0] cnt_r;
  logic [6:0] ptr_r;
  logic req_tgl_r;
  logic ack_tgl_r;
  logic ack_d_r;
  logic [7:0] rdata_l_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic dec_ack;
  logic scl_rise, scl_fall, bus_start, bus_stop, byte_end, slot_end;
  logic load_tx, req_go;
  logic [7:0] tx_byte;
  logic [7:0] rdata_r;

  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_end = scl_fall & ~in_ack_r & (bits_r == 4'h8) & (st_r != cg_pkg::ST_IDLE);
  assign slot_end = scl_fall & in_ack_r;
  assign load_tx = slot_end & (nxt_st_r == cg_pkg::ST_RD) & (st_r == cg_pkg::ST_ADDR | mack_r);
  assign tx_byte = (blk_r & cnt_pend_r) ? `CG_BLOCK_COUNT : rdata_l_r;

  // ***************************************************************
  // link domain: byte decisions
  // ***************************************************************
  always_comb begin
    dec_ack = 1'b0;
    dec_st = cg_pkg::ST_IDLE;
    case (st_r)
      cg_pkg::ST_ADDR: begin
        if (shift_r[7:1] == `CG_SLAVE_ADDR) begin
          dec_ack = 1'b1;
          dec_st = shift_r[0] ? cg_pkg::ST_RD : cg_pkg::ST_CMD;
        end
      end
      cg_pkg::ST_CMD: begin
        if (shift_r[7]) begin
          dec_ack = 1'b1;
          dec_st = cg_pkg::ST_WR;
        end else if (shift_r == `CG_BLOCK_CMD) begin
          dec_ack = 1'b1;
          dec_st = cg_pkg::ST_CNT;
        end
      end
      cg_pkg::ST_CNT: begin
        dec_ack = 1'b1;
        dec_st = cg_pkg::ST_WR;
      end
      cg_pkg::ST_WR: begin
        // every byte within the count is acknowledged, whatever it targets
        dec_ack = ~blk_r | (cnt_r != 8'h00);
        dec_st = cg_pkg::ST_WR;
      end
      cg_pkg::ST_RD: begin
        dec_st = cg_pkg::ST_RD;
      end
      default: begin
        dec_st = cg_pkg::ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // link domain: engine state and bit counting
  // ***************************************************************
  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      st_r <= cg_pkg::ST_IDLE;
      nxt_st_r <= cg_pkg::ST_IDLE;
      bits_r <= 4'h0;
      in_ack_r <= 1'b0;
    end else if (bus_start) begin
      st_r <= cg_pkg::ST_ADDR;
      bits_r <= 4'h0;
      in_ack_r <= 1'b0;
    end else if (bus_stop) begin
      st_r <= cg_pkg::ST_IDLE;
      in_ack_r <= 1'b0;
    end else if (byte_end) begin
      nxt_st_r <= dec_st;
      if (dec_ack || st_r == cg_pkg::ST_RD) begin
        in_ack_r <= 1'b1;
      end else begin
        st_r <= cg_pkg::ST_IDLE;
      end
    end else if (slot_end) begin
      in_ack_r <= 1'b0;
      bits_r <= 4'h0;
      if (st_r == cg_pkg::ST_RD && !mack_r) begin
        st_r <= cg_pkg::ST_IDLE;
      end else begin
        st_r <= nxt_st_r;
      end
    end else if (scl_rise && !in_ack_r && st_r != cg_pkg::ST_IDLE) begin
      bits_r <= bits_r + 4'h1;
    end
  end

  // shift register: receives on rising edges, doubles as transmit register
  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      shift_r <= 8'h00;
      mack_r <= 1'b0;
    end else if (load_tx) begin
      shift_r <= tx_byte;
    end else if (scl_rise && in_ack_r && st_r == cg_pkg::ST_RD) begin
      mack_r <= ~sda_s;
    end else if (scl_rise && !in_ack_r && st_r != cg_pkg::ST_IDLE) begin
      shift_r <= {shift_r[6:0], sda_s};
    end
  end

  // data line: ack slots and transmitted bits, open-drain low only
  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      sda_oe_r <= 1'b0;
      sda_o_r <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe_r <= 1'b0;
    end else if (byte_end) begin
      sda_oe_r <= dec_ack & (st_r != cg_pkg::ST_RD);
    end else if (slot_end) begin
      sda_oe_r <= load_tx & ~tx_byte[7];
    end else if (scl_fall && !in_ack_r && st_r == cg_pkg::ST_RD) begin
      sda_oe_r <= ~shift_r[7];
    end
  end

  // ***************************************************************
  // link domain: pointer, count and block mode
  // ***************************************************************
  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      ptr_r <= 7'h00;
      cnt_r <= 8'h00;
      blk_r <= 1'b0;
      cnt_pend_r <= 1'b0;
    end else if (byte_end && st_r == cg_pkg::ST_CMD && shift_r[7]) begin
      ptr_r <= shift_r[6:0];
      blk_r <= 1'b0;
    end else if (byte_end && st_r == cg_pkg::ST_CMD && shift_r == `CG_BLOCK_CMD) begin
      ptr_r <= 7'h00;
      blk_r <= 1'b1;
      cnt_pend_r <= 1'b1;
    end else if (byte_end && st_r == cg_pkg::ST_CNT) begin
      cnt_r <= shift_r;
      cnt_pend_r <= 1'b0;
    end else if (byte_end && st_r == cg_pkg::ST_WR && dec_ack && blk_r) begin
      ptr_r <= ptr_r + 7'h01;
      cnt_r <= cnt_r - 8'h01;
    end else if (load_tx) begin
      if (blk_r && cnt_pend_r) begin
        cnt_pend_r <= 1'b0;
      end else if (blk_r) begin
        ptr_r <= ptr_r + 7'h01;
      end
    end
  end

  // ***************************************************************
  // link domain: toggle handshake towards the register bank
  // ***************************************************************
  cg_sync u_ack_sync (
    .clk(smb_clk), .rst(rst_link), .d(ack_tgl_r), .q(ack_s)
  );

  assign req_go = byte_end & ((st_r == cg_pkg::ST_WR & dec_ack)
                  | (st_r == cg_pkg::ST_ADDR & dec_ack & shift_r[0])
                  | (st_r == cg_pkg::ST_RD));

  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      req_tgl_r <= 1'b0;
      req_pl_r <= '0;
    end else if (req_go && (req_tgl_r == ack_s)) begin
      req_tgl_r <= ~req_tgl_r;
      req_pl_r.we <= (st_r == cg_pkg::ST_WR);
      req_pl_r.addr <= ptr_r;
      req_pl_r.data <= shift_r;
    end
  end

  always_ff @(posedge smb_clk) begin
    if (rst_link) begin
      ack_d_r <= 1'b0;
      rdata_l_r <= 8'h00;
    end else begin
      ack_d_r <= ack_s;
      if (ack_s != ack_d_r) begin
        rdata_l_r <= rdata_r;
      end
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;

  // ***************************************************************
  // system domain: register bank
  // ***************************************************************
  logic req_s;
  logic req_d_r;
  logic req_new;
  logic wr_go;
  logic spread_r, gl_oe_r, ref_en_r;
  logic [3:0] diff_en_r;

  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic sp,
                                        input logic go, input logic re,
                                        input logic [3:0] de);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `CG_OFS_SPREAD: v = {sp, 1'b0, go, 4'h0, re};
      `CG_OFS_DIFF: v = {2'b00, de[3], de[2], 1'b0, de[1], de[0], 1'b0};
      `CG_OFS_IDENT: v = {`CG_REV_CODE, `CG_MAKER_CODE};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  cg_sync u_req_sync (
    .clk(clock), .rst(rst), .d(req_tgl_r), .q(req_s)
  );

  assign req_new = req_s ^ req_d_r;
  assign wr_go = req_new & req_pl_r.we;

  always_ff @(posedge clock) begin
    if (rst) begin
      req_d_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      req_d_r <= req_s;
      if (req_new) begin
        ack_tgl_r <= ~ack_tgl_r;
        rdata_r <= rd_mux(req_pl_r.addr, spread_r, gl_oe_r, ref_en_r, diff_en_r);
      end
    end
  end

  // only writable bits are stored; other bytes and bits fall through
  always_ff @(posedge clock) begin
    if (rst) begin
      spread_r <= `CG_RST_SPREAD;
      gl_oe_r <= `CG_RST_GLOBAL_OE;
      ref_en_r <= `CG_RST_REF_OE;
      diff_en_r <= `CG_RST_DIFF_EN;
    end else if (wr_go && req_pl_r.addr == `CG_OFS_SPREAD) begin
      spread_r <= req_pl_r.data[`CG_B0_SPREAD];
      gl_oe_r <= req_pl_r.data[`CG_B0_GLOBAL_OE];
      ref_en_r <= req_pl_r.data[`CG_B0_REF_OE];
    end else if (wr_go && req_pl_r.addr == `CG_OFS_DIFF) begin
      diff_en_r <= {req_pl_r.data[`CG_B3_EN3], req_pl_r.data[`CG_B3_EN2],
                    req_pl_r.data[`CG_B3_EN1], req_pl_r.data[`CG_B3_EN0]};
    end
  end

  // ***************************************************************
  // system domain: power-down filter and output gating
  // ***************************************************************
  logic pd_s;
  logic [3:0] pd_cnt_r;
  logic pd_act_r;
  logic run_ok;
  logic spread_on_r, ref_oe_r, ref_run_r, ref_weak_pd_r;
  logic [3:0] diff_drive_r;

  cg_sync #(.RST_VAL(1'b1)) u_pd_sync (
    .clk(clock), .rst(rst), .d(hw_powerdown_n), .q(pd_s)
  );

  // a low level is taken as power-down once it has lasted the minimum width
  always_ff @(posedge clock) begin
    if (rst) begin
      pd_cnt_r <= 4'h0;
      pd_act_r <= 1'b0;
    end else if (pd_s) begin
      pd_cnt_r <= 4'h0;
      pd_act_r <= 1'b0;
    end else if (pd_cnt_r == 4'(`CG_PD_MIN_CYC - 1)) begin
      pd_act_r <= 1'b1;
    end else begin
      pd_cnt_r <= pd_cnt_r + 4'h1;
    end
  end

  assign run_ok = ~pd_act_r & gl_oe_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      spread_on_r <= 1'b0;
      diff_drive_r <= 4'h0;
      ref_oe_r <= 1'b0;
      ref_run_r <= 1'b0;
      ref_weak_pd_r <= 1'b1;
    end else begin
      spread_on_r <= spread_r;
      diff_drive_r <= {4{run_ok}} & diff_en_r;
      ref_oe_r <= run_ok;
      ref_run_r <= run_ok & ref_en_r;
      ref_weak_pd_r <= ~run_ok;
    end
  end

  assign spread_on = spread_on_r;
  assign diff_drive = diff_drive_r;
  assign ref_oe = ref_oe_r;
  assign ref_run = ref_run_r;
  assign ref_weak_pd = ref_weak_pd_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_spread_follow;
    @(posedge clock) disable iff (rst)
      (wr_go && req_pl_r.addr == `CG_OFS_SPREAD) ##2 1'b1 |->
        spread_on == $past(req_pl_r.data[`CG_B0_SPREAD], 2);
  endproperty
  a_spread_follow: assert property (p_spread_follow) else $error("spread output wrong");

  property p_global_off;
    @(posedge clock) disable iff (rst)
      !gl_oe_r |=> (diff_drive == 4'h0) && !ref_oe && ref_weak_pd;
  endproperty
  a_global_off: assert property (p_global_off) else $error("outputs on while disabled");

  property p_ref_low;
    @(posedge clock) disable iff (rst)
      (run_ok && !ref_en_r) |=> ref_oe && !ref_run;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("25 MHz not held low");

  property p_diff_write;
    @(posedge clock) disable iff (rst)
      (wr_go && req_pl_r.addr == `CG_OFS_DIFF) |=>
        diff_en_r == {$past(req_pl_r.data[5]), $past(req_pl_r.data[4]),
                      $past(req_pl_r.data[2]), $past(req_pl_r.data[1])};
  endproperty
  a_diff_write: assert property (p_diff_write) else $error("output enables wrong");

  property p_byte3_fixed;
    @(posedge clock) disable iff (rst)
      (req_new && req_pl_r.addr == `CG_OFS_DIFF) |=> (rdata_r & 8'hc9) == 8'h00;
  endproperty
  a_byte3_fixed: assert property (p_byte3_fixed) else $error("fixed bits not zero");

  property p_ident;
    @(posedge clock) disable iff (rst)
      (req_new && req_pl_r.addr == `CG_OFS_IDENT) |=> rdata_r == 8'h35;
  endproperty
  a_ident: assert property (p_ident) else $error("identity byte wrong");

  property p_pd_gate;
    @(posedge clock) disable iff (rst)
      pd_act_r |=> (diff_drive == 4'h0) && !ref_run && ref_weak_pd;
  endproperty
  a_pd_gate: assert property (p_pd_gate) else $error("outputs on in power-down");

  property p_byte_cmd;
    @(posedge smb_clk) disable iff (rst_link)
      (byte_end && st_r == cg_pkg::ST_CMD && shift_r[7]) |=>
        ptr_r == $past(shift_r[6:0]) && !blk_r && in_ack_r && sda_oe;
  endproperty
  a_byte_cmd: assert property (p_byte_cmd) else $error("byte command not taken");

  property p_block_cmd;
    @(posedge smb_clk) disable iff (rst_link)
      (byte_end && st_r == cg_pkg::ST_CMD && shift_r == 8'h00) |=>
        ptr_r == 7'h00 && blk_r && nxt_st_r == cg_pkg::ST_CNT;
  endproperty
  a_block_cmd: assert property (p_block_cmd) else $error("block command not taken");

  property p_unused_write;
    @(posedge clock) disable iff (rst)
      (wr_go && req_pl_r.addr != `CG_OFS_SPREAD && req_pl_r.addr != `CG_OFS_DIFF) |=>
        $stable(spread_r) && $stable(gl_oe_r) && $stable(ref_en_r) && $stable(diff_en_r);
  endproperty
  a_unused_write: assert property (p_unused_write) else $error("unused write changed state");

endmodule // cg_ctrl_regs

// file: verif/cg_smb_host.sv
// serial bus host model that drives the clock generator's control link
`timescale 1ns/100ps
module cg_smb_host (
  // link clock that paces every bus phase
  input wire logic smb_clk,
  // slave side of the data line
  input wire logic sda_o,
  input wire logic sda_oe,
  // bus lines as every party sees them
  output logic scl,
  output logic sda_line
);
  logic sda_r;

  // open-drain line with pull-up: a released line reads high
  assign sda_line = sda_r & ~(sda_oe & ~sda_o);

  initial begin
    scl = 1'b1;
    sda_r = 1'b1;
  end

  // ***************************************************************
  // bus phases
  // ***************************************************************
  task automatic wt(input int n);
    repeat (n) @(negedge smb_clk);
  endtask

  // low phase of 13 link cycles leaves room for the register crossing
  task automatic bit_c(input logic b, output logic seen);
    wt(2);
    sda_r = b;
    wt(11);
    seen = sda_line;
    scl = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic start_c();
    sda_r = 1'b1;
    wt(4);
    sda_r = 1'b0;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic rstart_c();
    wt(2);
    sda_r = 1'b1;
    wt(11);
    scl = 1'b1;
    wt(4);
    sda_r = 1'b0;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic stop_c();
    wt(2);
    sda_r = 1'b0;
    wt(11);
    scl = 1'b1;
    wt(4);
    sda_r = 1'b1;
    wt(4);
  endtask

  // bytes go most significant bit first; ack is true when the slave pulls low
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    bit_c(~mack, s);
  endtask
endmodule // cg_smb_host

// file: verif/cg_ctrl_regs_tb_top.sv
// self-checking testbench of the clock generator control registers
`timescale 1ns/100ps
`include "cg_defs.svh"
module cg_ctrl_regs_tb_top;
  logic clock, rst, smb_clk, hw_powerdown_n, scl, sda_line, sda_o, sda_oe;
  logic spread_on, ref_oe, ref_run, ref_weak_pd;
  logic [3:0] diff_drive;
  int n_mismatch, comparisons, cycles;

  always #5 clock = ~clock;
  initial begin
    smb_clk = 1'b0;
    #1.7;
    forever #62.5 smb_clk = ~smb_clk;
  end

  cg_ctrl_regs u_dut (.clock(clock), .rst(rst), .smb_clk(smb_clk), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .hw_powerdown_n(hw_powerdown_n),
    .spread_on(spread_on), .diff_drive(diff_drive), .ref_oe(ref_oe), .ref_run(ref_run),
    .ref_weak_pd(ref_weak_pd));
  cg_smb_host u_host (.smb_clk(smb_clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl),
    .sda_line(sda_line));

  // ***************************************************************
  // checking helpers
  // ***************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      n_mismatch++;
      summarize();
    end
  end

  // outputs expected from byte 0 and byte 3 contents
  task automatic outs(input logic [7:0] b, input logic [7:0] d);
    logic g;
    g = b[`CG_B0_GLOBAL_OE];
    @(negedge clock);
    check({7'h00, spread_on}, {7'h00, b[`CG_B0_SPREAD]});
    check({4'h0, diff_drive}, g ? {4'h0, d[5], d[4], d[2], d[1]} : 8'h00);
    check({5'h00, ref_oe, ref_run, ref_weak_pd}, {5'h00, g, g & b[0], ~g});
  endtask

  task automatic send_ok(input logic [7:0] d);
    logic ack;
    u_host.send_byte(d, ack);
    check({7'h00, ack}, 8'h01);
  endtask

  task automatic wr_byte(input logic [6:0] ofs, input logic [7:0] d);
    u_host.start_c();
    send_ok({`CG_SLAVE_ADDR, 1'b0});
    send_ok({1'b1, ofs});
    send_ok(d);
    u_host.stop_c();
  endtask

  task automatic rd_byte(input logic [6:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    u_host.start_c();
    send_ok({`CG_SLAVE_ADDR, 1'b0});
    send_ok({1'b1, ofs});
    u_host.rstart_c();
    send_ok({`CG_SLAVE_ADDR, 1'b1});
    u_host.recv_byte(1'b0, d);
    u_host.stop_c();
    check(d, exp);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic s_block_read();
    logic [7:0] d;
    logic [7:0] exp [7] = '{8'ha1, 8'h00, 8'h00, 8'h36, 8'h00,
      {`CG_REV_CODE, `CG_MAKER_CODE}, 8'h00};
    u_host.start_c();
    send_ok({`CG_SLAVE_ADDR, 1'b0});
    send_ok(`CG_BLOCK_CMD);
    u_host.rstart_c();
    send_ok({`CG_SLAVE_ADDR, 1'b1});
    u_host.recv_byte(1'b1, d);
    check(d, `CG_BLOCK_COUNT);
    for (int i = 0; i < 7; i++) begin
      u_host.recv_byte(i < 6, d);
      check(d, exp[i]);
    end
    u_host.stop_c();
  endtask

  // block write from register 0: ignored bytes and bits must not stick
  task automatic s_block_write();
    logic ack;
    u_host.start_c();
    send_ok({`CG_SLAVE_ADDR, 1'b0});
    send_ok(`CG_BLOCK_CMD);
    send_ok(8'h04);
    send_ok(8'ha1);
    send_ok(8'hff);
    send_ok(8'hff);
    send_ok(8'h12);
    // a byte beyond the count is refused
    u_host.send_byte(8'h36, ack);
    check({7'h00, ack}, 8'h00);
    u_host.stop_c();
    outs(8'ha1, 8'h12);
    rd_byte(`CG_OFS_UNUSED1, 8'h00);
  endtask

  task automatic s_refused();
    logic ack;
    u_host.start_c();
    u_host.send_byte({`CG_SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    check({7'h00, ack}, 8'h00);
    u_host.stop_c();
    u_host.start_c();
    send_ok({`CG_SLAVE_ADDR, 1'b0});
    u_host.send_byte(8'h01, ack);
    check({7'h00, ack}, 8'h00);
    u_host.stop_c();
    outs(8'ha1, 8'h12);
  endtask

  task automatic s_powerdown();
    @(negedge clock);
    hw_powerdown_n = 1'b0;
    repeat (5) @(negedge clock);
    hw_powerdown_n = 1'b1;
    repeat (20) begin
      @(negedge clock);
      check({7'h00, ref_oe}, 8'h01);
    end
    hw_powerdown_n = 1'b0;
    repeat (30) @(negedge clock);
    outs(8'h81, 8'h12);
    hw_powerdown_n = 1'b1;
    repeat (10) @(negedge clock);
    outs(8'ha1, 8'h12);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    hw_powerdown_n = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    // long enough for the link clock domain to see the reset too
    repeat (40) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge smb_clk);
    outs(8'ha1, 8'h36);
    s_block_read();
    wr_byte(`CG_OFS_SPREAD, 8'h00);
    outs(8'h00, 8'h36);
    wr_byte(`CG_OFS_SPREAD, 8'h20);
    outs(8'h20, 8'h36);
    wr_byte(`CG_OFS_DIFF, 8'hc9);
    outs(8'h20, 8'hc9);
    rd_byte(`CG_OFS_DIFF, 8'h00);
    s_block_write();
    s_refused();
    s_powerdown();
    summarize();
  end
endmodule // cg_ctrl_regs_tb_top
